// ---- hw/fls_pkg.sv ----
// Purpose: Shared constants and carrier types for the flash read-path block.
// Assumes: One 32-bit word per array location; host pins arrive asynchronously.
// Notes: Command codes and reset values are local encodings of this model.

// ****************************************************************
// Package
// ****************************************************************
package fls_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CFG_W = 16;
	// Configuration register layout and reset value (asynchronous reads).
	localparam int CFG_MODE_BIT = 15;
	localparam int DLY_LSB = 10;
	localparam int DLY_W = 4;
	localparam logic [4:0] DLY_BASE = 5'h02;
	localparam logic [CFG_W-1:0] CFG_RESET = 16'h8400;
	// Command codes carried in data[31:24] of a write cycle.
	localparam logic [7:0] CMD_SET_CFG = 8'hD0;
	localparam logic [7:0] CMD_READ_CFG = 8'hC6;
	localparam logic [7:0] CMD_PROGRAM = 8'hA0;
	localparam logic [7:0] CMD_SEC_ENTER = 8'h88;
	localparam logic [7:0] CMD_RESET = 8'hF0;
	// Burst group length and security region size in words (256 bytes).
	localparam int BURST_LEN = 8;
	localparam int SEC_WORDS = 64;
	localparam int FIFO_DEPTH = 8;
	// Timing counts in mclk cycles.
	localparam int PROG_CYCLES = 64;
	localparam int RST_BUSY_CYCLES = 16;
	// Contents left behind by a program that reset cut short.
	localparam logic [DATA_W-1:0] INVALID_WORD = 32'hFFFF_0000;

	// Host pins as seen by the device.
	typedef struct packed {
		logic selectN;
		logic outGateN;
		logic writeN;
		logic advN;
		logic hwResetN;
		logic burstClk;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} fls_pins_type;

	// Device drive toward the host.
	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic dataOe;
	} fls_drive_type;
endpackage

// ---- hw/fls_pin_sync.sv ----
// Purpose: Two-stage synchroniser for a vector of host pins.
// Assumes: Multi-bit groups are held stable by the host around the sampled event.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/10ps
`default_nettype none

module fls_pin_sync #(
	parameter int W = 8
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset_n,
	// Pins in and synchronised copy out.
	input wire logic [W-1:0] pinIn,
	output logic [W-1:0] pinSync
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// Both stages settle to idle-high pins under reset.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			meta_q <= '1;
			sync_q <= '1;
		end else begin
			meta_q <= pinIn;
			sync_q <= meta_q;
		end
	end

	assign pinSync = sync_q;
endmodule
`default_nettype wire

// ---- hw/fls_fifo.sv ----
// Purpose: Small word buffer between the burst prefetcher and the output stage.
// Assumes: DEPTH is a power of two.
// Notes: Flush empties the buffer in one cycle when a burst ends or restarts.
`timescale 1ns/10ps
`default_nettype none

module fls_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	// Clock, reset and flush.
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic flush,
	// Filling side.
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// Draining side.
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] store [DEPTH];
	logic [PW-1:0] wrPtr_q;
	logic [PW-1:0] rdPtr_q;
	logic [PW:0] count_q;
	logic push;
	logic pop;

	// Honest flags: full stalls the source, empty holds the drain.
	assign inReady = (count_q != (PW+1)'(DEPTH));
	assign outValid = (count_q != '0);
	assign push = inValid & inReady;
	assign pop = outValid & outReady;
	assign outData = store[rdPtr_q];

	// Pointer and occupancy bookkeeping.
	always_ff @(posedge mclk) begin
		if (!reset_n || flush) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			wrPtr_q <= wrPtr_q + PW'(push);
			rdPtr_q <= rdPtr_q + PW'(pop);
			count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	// Storage has no reset; only written words are ever read.
	always_ff @(posedge mclk) begin
		if (push) begin
			store[wrPtr_q] <= inData;
		end
	end
endmodule
`default_nettype wire

// ---- hw/fls_read_ctrl.sv ----
// Purpose: Read path, hardware reset and burst entry of a parallel NOR flash.
// Assumes: Host pins, burst clock included, are asynchronous to mclk.
// Notes: Burst clock must be several mclk periods long so its edges are seen.
//
// Behaviour
// - Reset or power-up enters asynchronous array read.
// - Plain read returns array data without command.
// - Array read stays until a command write.
// - Hardware reset aborts any mode or operation.
// - Data outputs float while hardware reset low.
// - Busy stays low after reset during program.
// - Interrupted program leaves invalid word; rewrite it.
// - Burst disabled until configuration write enables.
// - Delay field sets initial burst wait states.
// - Burst enabled: array reads follow burst protocol.
// - Following burst words track host clock.
// - Initial access counts from first edge after latch.
// - Security region same timing; no boundary crossing.
// - Burst only for array reads, security region included.
// - Configuration reads are single cycle always.
// - Configuration data held while output gate low.
// - Reset during burst floats bus, restores defaults.
// - Read mode bit: zero burst, one async.
`timescale 1ns/10ps
`default_nettype none

module fls_read_ctrl
	import fls_pkg::*;
#(
	parameter int DEPTH = 256,
	parameter int PROG_CNT = PROG_CYCLES,
	parameter int RST_BUSY_CNT = RST_BUSY_CYCLES
) (
	// Clock and synchronous reset.
	input wire logic mclk,
	input wire logic reset_n,
	// Host pins, asynchronous.
	input wire fls_pins_type pins,
	// Device drive and status pins.
	output fls_drive_type drive,
	output logic readyBusyN
);
	// ****************************************************************
	// Pin synchronisation and edge detection
	// ****************************************************************
	localparam int PIN_W = $bits(fls_pins_type);
	typedef enum logic [5:0] {
		ST_ASYNC = 6'h01,
		ST_CFGRD = 6'h02,
		ST_BWAIT = 6'h04,
		ST_BDATA = 6'h08,
		ST_PROG = 6'h10,
		ST_RSTBUSY = 6'h20
	} fls_state_type;

	fls_pins_type p;
	logic [PIN_W-1:0] pSync;
	logic clkPrev_q;
	logic wrPrev_q;

	fls_pin_sync #(.W(PIN_W)) u_sync (
		.mclk(mclk),
		.reset_n(reset_n),
		.pinIn(pins),
		.pinSync(pSync)
	);
	assign p = fls_pins_type'(pSync);

	// Previous levels of the synchronised clock and write strobe.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			clkPrev_q <= 1'b1;
			wrPrev_q <= 1'b1;
		end else begin
			clkPrev_q <= p.burstClk;
			wrPrev_q <= p.writeN;
		end
	end

	// ****************************************************************
	// Decode
	// ****************************************************************
	fls_state_type state_q, state_d;
	logic [CFG_W-1:0] cfg_q, cfg_d;
	logic secMode_q, secMode_d;
	logic progPend_q, progPend_d;
	logic [ADDR_W-1:0] progAddr_q, progAddr_d;
	logic [DATA_W-1:0] progData_q, progData_d;
	logic [15:0] busyCnt_q, busyCnt_d;
	logic [4:0] dly_q, dly_d;
	logic [ADDR_W-1:0] base_q, base_d;
	logic [2:0] fetchIdx_q;
	logic [DATA_W-1:0] dataOut_q, dataOut_d;
	logic dataOe_q;
	logic busyN_q;
	logic [DATA_W-1:0] mem [DEPTH];
	logic [DATA_W-1:0] secMem [SEC_WORDS];

	logic clkRise;
	logic wrEnd;
	logic hwReset;
	logic readAllowed;
	logic burstMode;
	logic burstGo;
	logic inBurst;
	logic [7:0] cmd;
	logic [DATA_W-1:0] arrayRd;
	logic [ADDR_W-1:0] fetchAddr;
	logic [DATA_W-1:0] fetchData;
	logic fifoInReady;
	logic fifoOutValid;
	logic fifoPop;
	logic fifoFlush;
	logic [DATA_W-1:0] fifoOut;
	logic progDone;
	logic progAbort;

	assign clkRise = p.burstClk & ~clkPrev_q;
	assign wrEnd = p.writeN & ~wrPrev_q & ~p.selectN;
	assign hwReset = ~p.hwResetN;
	// Data is offered only to a selected, gated, non-writing host.
	assign readAllowed = ~p.selectN & ~p.outGateN & p.writeN;
	assign burstMode = ~cfg_q[CFG_MODE_BIT];
	assign inBurst = (state_q == ST_BWAIT) || (state_q == ST_BDATA);
	// Bursts start only from array reads, never from configuration reads.
	assign burstGo = burstMode & ~p.selectN & ~p.advN & clkRise & ~hwReset
		& ((state_q == ST_ASYNC) | inBurst);
	assign cmd = p.data[DATA_W-1:DATA_W-8];
	// Security words share the array timing path.
	assign arrayRd = secMode_q ? secMem[p.addr[5:0]] : mem[p.addr];
	// Linear wrap inside the group of eight; a group never straddles the region end.
	assign fetchAddr = {base_q[ADDR_W-1:3], base_q[2:0] + fetchIdx_q};
	assign fetchData = secMode_q ? secMem[fetchAddr[5:0]] : mem[fetchAddr];
	assign fifoPop = (state_q == ST_BDATA || (state_q == ST_BWAIT && dly_q == 5'h01))
		& clkRise & ~hwReset;
	assign fifoFlush = burstGo | ~inBurst;
	assign progDone = (state_q == ST_PROG) & (busyCnt_q == 16'h0000);
	assign progAbort = (state_q == ST_PROG) & hwReset;

	fls_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.mclk(mclk),
		.reset_n(reset_n),
		.flush(fifoFlush),
		.inValid(inBurst),
		.inReady(fifoInReady),
		.inData(fetchData),
		.outValid(fifoOutValid),
		.outReady(fifoPop),
		.outData(fifoOut)
	);

	// ****************************************************************
	// Mode and command sequencing
	// ****************************************************************
	// Next-state logic; hardware reset, checked last, overrides the state, configuration, mode and busy decisions above it.
	always_comb begin
		state_d = state_q;
		cfg_d = cfg_q;
		secMode_d = secMode_q;
		progPend_d = progPend_q;
		progAddr_d = progAddr_q;
		progData_d = progData_q;
		busyCnt_d = busyCnt_q;
		dly_d = dly_q;
		base_d = base_q;
		unique case (state_q)
			ST_ASYNC, ST_CFGRD, ST_BWAIT, ST_BDATA: begin
				if (inBurst && p.selectN) begin
					state_d = ST_ASYNC;
				end
				if (state_q == ST_BWAIT && clkRise) begin
					dly_d = dly_q - 5'h01;
					if (dly_q == 5'h01) begin
						state_d = ST_BDATA;
					end
				end
				if (burstGo) begin
					state_d = ST_BWAIT;
					base_d = p.addr;
					dly_d = {1'b0, cfg_q[DLY_LSB +: DLY_W]} + DLY_BASE;
				end
				if (wrEnd) begin
					// Any command write returns to array reading unless it starts a configuration read or a program.
					state_d = ST_ASYNC;
					if (progPend_q) begin
						state_d = ST_PROG;
						progPend_d = 1'b0;
						progAddr_d = p.addr;
						progData_d = p.data;
						busyCnt_d = 16'(PROG_CNT);
					end else if (cmd == CMD_SET_CFG) begin
						cfg_d = p.data[CFG_W-1:0];
					end else if (cmd == CMD_READ_CFG) begin
						state_d = ST_CFGRD;
					end else if (cmd == CMD_SEC_ENTER) begin
						secMode_d = 1'b1;
					end else if (cmd == CMD_PROGRAM) begin
						progPend_d = 1'b1;
					end else if (cmd == CMD_RESET) begin
						secMode_d = 1'b0;
					end
				end
			end
			ST_PROG: begin
				busyCnt_d = busyCnt_q - 16'h0001;
				if (progDone) begin
					state_d = ST_ASYNC;
				end
			end
			ST_RSTBUSY: begin
				busyCnt_d = busyCnt_q - 16'h0001;
				if (busyCnt_q == 16'h0000) begin
					state_d = ST_ASYNC;
				end
			end
			default: begin
				state_d = ST_ASYNC;
			end
		endcase
		if (hwReset) begin
			// Abort any mode; a program in flight keeps busy for its recovery.
			cfg_d = CFG_RESET;
			secMode_d = 1'b0;
			progPend_d = 1'b0;
			if (state_q == ST_PROG || state_q == ST_RSTBUSY) begin
				state_d = ST_RSTBUSY;
				busyCnt_d = 16'(RST_BUSY_CNT);
			end else begin
				state_d = ST_ASYNC;
			end
		end
	end

	// State registers; power-up lands in asynchronous array read.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			state_q <= ST_ASYNC;
			cfg_q <= CFG_RESET;
			secMode_q <= 1'b0;
			progPend_q <= 1'b0;
			progAddr_q <= '0;
			progData_q <= '0;
			busyCnt_q <= '0;
			dly_q <= '0;
			base_q <= '0;
		end else begin
			state_q <= state_d;
			cfg_q <= cfg_d;
			secMode_q <= secMode_d;
			progPend_q <= progPend_d;
			progAddr_q <= progAddr_d;
			progData_q <= progData_d;
			busyCnt_q <= busyCnt_d;
			dly_q <= dly_d;
			base_q <= base_d;
		end
	end

	// Prefetch index walks the group while the buffer accepts words.
	always_ff @(posedge mclk) begin
		if (!reset_n || fifoFlush) begin
			fetchIdx_q <= '0;
		end else if (fifoInReady) begin
			fetchIdx_q <= fetchIdx_q + 3'h1;
		end
	end

	// Array update; a cut-short program leaves a garbage word behind.
	always_ff @(posedge mclk) begin
		if (progDone || progAbort) begin
			if (secMode_q) begin
				secMem[progAddr_q[5:0]] <= progAbort ? INVALID_WORD : progData_q;
			end else begin
				mem[progAddr_q] <= progAbort ? INVALID_WORD : progData_q;
			end
		end
	end

	// ****************************************************************
	// Output stage
	// ****************************************************************
	// Configuration reads ignore the clock and hold while gated on.
	always_comb begin
		dataOut_d = dataOut_q;
		if (state_q == ST_CFGRD) begin
			dataOut_d = {{(DATA_W-CFG_W){1'b0}}, cfg_q};
		end else if (inBurst) begin
			if (fifoPop && fifoOutValid) begin
				dataOut_d = fifoOut;
			end
		end else begin
			dataOut_d = arrayRd;
		end
	end

	// Drive registers; the bus floats in reset, deselect and wait states.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			dataOut_q <= '0;
			dataOe_q <= 1'b0;
			busyN_q <= 1'b1;
		end else begin
			dataOut_q <= dataOut_d;
			dataOe_q <= readAllowed & ~hwReset & (state_d != ST_BWAIT);
			busyN_q <= (state_d != ST_PROG) && (state_d != ST_RSTBUSY);
		end
	end

	assign drive = '{data: dataOut_q, dataOe: dataOe_q};
	assign readyBusyN = busyN_q;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	sequence s_abort;
		(state_q == ST_PROG) && hwReset;
	endsequence
	sequence s_last_wait;
		(state_q == ST_BWAIT) && clkRise && (dly_q == 5'h01) && !hwReset && !p.selectN && !burstGo && !wrEnd;
	endsequence

	property p_float_reset;
		hwReset |=> !dataOe_q;
	endproperty
	a_float_reset: assert property (p_float_reset) else $error("bus driven during reset");

	property p_float_desel;
		(p.selectN || p.outGateN) |=> !dataOe_q;
	endproperty
	a_float_desel: assert property (p_float_desel) else $error("bus driven while off");

	property p_busy_abort;
		s_abort |=> !readyBusyN[*4];
	endproperty
	a_busy_abort: assert property (p_busy_abort) else $error("busy released too early");

	property p_reset_defaults;
		hwReset |=> (cfg_q == CFG_RESET) && !secMode_q && !inBurst;
	endproperty
	a_reset_defaults: assert property (p_reset_defaults) else $error("reset kept mode");

	property p_cfg_read;
		(state_q == ST_CFGRD) && readAllowed && !hwReset
			|=> dataOe_q && (dataOut_q == {{(DATA_W-CFG_W){1'b0}}, $past(cfg_q)});
	endproperty
	a_cfg_read: assert property (p_cfg_read) else $error("config read wrong");

	property p_async_mode;
		cfg_q[CFG_MODE_BIT] |-> !inBurst;
	endproperty
	a_async_mode: assert property (p_async_mode) else $error("burst in async mode");

	property p_burst_start;
		burstGo && !wrEnd |=> (state_q == ST_BWAIT) && (dly_q == $past({1'b0, cfg_q[DLY_LSB +: DLY_W]}) + DLY_BASE);
	endproperty
	a_burst_start: assert property (p_burst_start) else $error("burst entry wrong");

	property p_first_word;
		s_last_wait |=> (state_q == ST_BDATA);
	endproperty
	a_first_word: assert property (p_first_word) else $error("first word late");

	property p_pop_data;
		fifoPop && fifoOutValid |=> dataOut_q == $past(fifoOut);
	endproperty
	a_pop_data: assert property (p_pop_data) else $error("burst word lost");

	property p_array_read;
		(state_q == ST_ASYNC) && !burstGo && readAllowed && !hwReset |=> dataOut_q == $past(arrayRd);
	endproperty
	a_array_read: assert property (p_array_read) else $error("array read wrong");
endmodule
`default_nettype wire

// ---- test/fls_host_model.sv ----
// Purpose: Host memory controller model that drives the flash pins.
// Assumes: Every pin change lands 1 ns after an mclk rise.
// Notes: The burst clock runs only inside bursts, 8 mclk per period.
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Host model
// ****************************************************************
module fls_host_model
	import fls_pkg::*;
(
	// Clock and device status.
	input wire logic mclk,
	input wire logic readyBusyN,
	// Pins toward the device.
	output var fls_pins_type pins
);
	// Idle bus at time zero; hardware reset stays low until released.
	initial begin
		pins = '0;
		pins.selectN = 1'b1;
		pins.outGateN = 1'b1;
		pins.writeN = 1'b1;
		pins.advN = 1'b1;
	end

	// Wait n mclk rises, then step just past the edge.
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// One write cycle; the device takes it on the strobe's rising edge.
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		pins.selectN = 1'b0;
		pins.outGateN = 1'b1;
		pins.addr = a;
		pins.data = d;
		pins.writeN = 1'b0;
		tick(3);
		pins.writeN = 1'b1;
		tick(3);
		pins.selectN = 1'b1;
		pins.data = ~d; // Released lines must not keep their last value.
		tick(1);
	endtask

	// Plain read with the write strobe high.
	task automatic rd(input logic [ADDR_W-1:0] a, input logic sel, input logic gate);
		pins.writeN = 1'b1;
		pins.advN = 1'b1;
		pins.selectN = sel;
		pins.outGateN = gate;
		pins.addr = a;
		tick(6);
	endtask

	// Latch a start address; bursts read the current region and wrap in groups.
	task automatic burst_start(input logic [ADDR_W-1:0] a);
		pins.writeN = 1'b1;
		pins.selectN = 1'b0;
		pins.outGateN = 1'b0;
		pins.addr = a;
		pins.advN = 1'b0;
		tick(4);
		pins.burstClk = 1'b1;
		tick(4);
		pins.burstClk = 1'b0;
		pins.advN = 1'b1;
		tick(3);
	endtask

	// One burst clock period, ending just before the next rise.
	task automatic clk_cycle();
		tick(1);
		pins.burstClk = 1'b1;
		tick(4);
		pins.burstClk = 1'b0;
		tick(3);
	endtask

	// Deselect ends any burst; the clock is already parked low.
	task automatic idle();
		tick(1);
		pins.selectN = 1'b1;
		pins.outGateN = 1'b1;
		pins.addr = ~pins.addr;
		tick(4);
	endtask

	// Drive the hardware reset pin and let it settle.
	task automatic hw_rst(input logic v);
		pins.hwResetN = v;
		tick(6);
	endtask

	// Access only after ready returns, covering both recovery waits.
	task automatic wait_ready();
		for (int i = 0; i < 200 && readyBusyN !== 1'b1; i++) begin
			tick(1);
		end
	endtask
endmodule
`default_nettype wire

// ---- test/fls_read_ctrl_tb_top.sv ----
// Purpose: Self-checking bench for the flash read path and its buffer.
// Assumes: Short program and recovery counts keep the run brief.
// Notes: Expected data comes from a shadow copy of programmed words.
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Bench top
// ****************************************************************
module fls_read_ctrl_tb_top
	import fls_pkg::*;
;
	localparam int PROG_N = 8;
	localparam int RBUSY_N = 4;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	fls_pins_type pins;
	fls_drive_type drive;
	logic readyBusyN;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	logic [DATA_W-1:0] mem [256];
	logic [15:0] cfg;
	logic [ADDR_W-1:0] base;
	logic [ADDR_W-1:0] st;
	logic [DATA_W-1:0] secWord;

	// Clock at 25 MHz.
	always #20 mclk = ~mclk;

	fls_read_ctrl #(.DEPTH(256), .PROG_CNT(PROG_N), .RST_BUSY_CNT(RBUSY_N)) dut (
		.mclk(mclk), .reset_n(reset_n), .pins(pins), .drive(drive), .readyBusyN(readyBusyN));
	fls_host_model host (.mclk(mclk), .readyBusyN(readyBusyN), .pins(pins));

	// Compare and count; an unknown never passes.
	task automatic chk(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("Checks %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Burst order wraps inside the aligned group of eight.
	function automatic logic [ADDR_W-1:0] burst_addr(input logic [ADDR_W-1:0] s, input int i);
		return {s[ADDR_W-1:3], s[2:0] + 3'(i)};
	endfunction

	// Configuration reads show the register low, zeros above.
	function automatic logic [DATA_W-1:0] cfg_word(input logic [15:0] c);
		return {16'h0000, c};
	endfunction

	// Program one word and track busy around it.
	task automatic prog(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		host.wr(8'h00, {CMD_PROGRAM, 24'h000000});
		host.wr(a, d);
		host.tick(1);
		chk("busy in program", {31'h0, readyBusyN}, 32'h0);
		host.wait_ready();
		chk("ready after program", {31'h0, readyBusyN}, 32'h1);
		mem[a] = d;
	endtask

	// Read; data counts only while selected and gated.
	task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic sel,
		input logic gate, input logic [DATA_W-1:0] exp);
		host.rd(a, sel, gate);
		chk(what, {31'h0, drive.dataOe}, {31'h0, !sel && !gate});
		if (!sel && !gate) begin
			chk(what, drive.data, exp);
		end
	endtask

	// Configuration read, then back to the array.
	task automatic cfg_chk(input logic [15:0] c);
		host.wr(8'h00, {CMD_READ_CFG, 24'h000000});
		rd_chk("config read", 8'h00, 1'b0, 1'b0, cfg_word(c));
		host.wr(8'h00, {CMD_RESET, 24'h000000});
	endtask

	// Main sequence.
	initial begin
		void'($urandom(32'h0FF0));
		repeat (5) @(posedge mclk);
		#1;
		reset_n = 1'b1;
		host.hw_rst(1'b1);
		chk("oe after reset", {31'h0, drive.dataOe}, 32'h0);
		chk("ready after reset", {31'h0, readyBusyN}, 32'h1);
		cfg_chk(CFG_RESET);
		$display("Test reset state done");
		base = 8'($urandom % 30) << 3;
		for (int i = 0; i < 8; i++) begin
			prog(base + 8'(i), $urandom);
		end
		prog(8'hFF, 32'hA5A5_5A5A);
		for (int i = 0; i < 16; i++) begin
			st = base + 8'($urandom % 8);
			rd_chk("array read", st, 1'b0, 1'b0, mem[st]);
		end
		rd_chk("top word", 8'hFF, 1'b0, 1'b0, mem[8'hFF]);
		rd_chk("gate high", base, 1'b0, 1'b1, 32'h0);
		rd_chk("deselected", base, 1'b1, 1'b0, 32'h0);
		host.idle();
		$display("Test array reads done");
		// Every delay code with a random start; the run covers a wrap.
		for (int d = 0; d < 16; d++) begin
			cfg = 16'(d) << DLY_LSB;
			host.wr(8'h00, {CMD_SET_CFG, 8'h00, cfg});
			st = base + 8'($urandom % 8);
			host.burst_start(st);
			for (int k = 1; k < d + 12; k++) begin
				host.clk_cycle();
				if (k < d + 2) begin
					chk("burst wait oe", {31'h0, drive.dataOe}, 32'h0);
				end else begin
					chk("burst word", drive.data, mem[burst_addr(st, k - d - 2)]);
				end
			end
			host.idle();
		end
		$display("Test burst delays done");
		host.wr(8'h00, {CMD_READ_CFG, 24'h000000});
		host.burst_start(st);
		for (int k = 0; k < 6; k++) begin
			host.clk_cycle();
			chk("config held", drive.data, cfg_word(cfg));
		end
		host.idle();
		host.wr(8'h00, {CMD_RESET, 24'h000000});
		$display("Test config in burst mode done");
		host.burst_start(st);
		repeat (cfg[13:10] + 4) host.clk_cycle();
		chk("oe in burst", {31'h0, drive.dataOe}, 32'h1);
		host.hw_rst(1'b0);
		chk("oe in reset", {31'h0, drive.dataOe}, 32'h0);
		host.hw_rst(1'b1);
		host.idle();
		rd_chk("async after reset", st, 1'b0, 1'b0, mem[st]);
		cfg_chk(CFG_RESET);
		$display("Test reset in burst done");
		host.wr(8'h00, {CMD_PROGRAM, 24'h000000});
		host.wr(base, ~mem[base]);
		host.hw_rst(1'b0);
		host.tick(10);
		chk("busy in reset", {31'h0, readyBusyN}, 32'h0);
		host.hw_rst(1'b1);
		chk("busy after release", {31'h0, readyBusyN}, 32'h0);
		host.wait_ready();
		chk("ready after recovery", {31'h0, readyBusyN}, 32'h1);
		rd_chk("aborted word", base, 1'b0, 1'b0, INVALID_WORD);
		prog(base, mem[base]);
		rd_chk("rewritten word", base, 1'b0, 1'b0, mem[base]);
		host.idle();
		$display("Test reset in program done");
		// Security region: its own words, same timing, left by the reset command.
		host.wr(8'h00, {CMD_SEC_ENTER, 24'h000000});
		secWord = $urandom;
		host.wr(8'h00, {CMD_PROGRAM, 24'h000000});
		host.wr(8'hC5, secWord);
		host.wait_ready();
		rd_chk("secure word", 8'hC5, 1'b0, 1'b0, secWord);
		host.wr(8'h00, {CMD_RESET, 24'h000000});
		rd_chk("main after secure", base, 1'b0, 1'b0, mem[base]);
		$display("Test security region done");
		// Stall the burst clock so the prefetch buffer fills, then drain it over two wraps.
		cfg = 16'h0000;
		host.wr(8'h00, {CMD_SET_CFG, 8'h00, cfg});
		st = base + 8'($urandom % 8);
		host.burst_start(st);
		host.clk_cycle();
		chk("fifo stall oe", {31'h0, drive.dataOe}, 32'h0);
		host.tick(40);
		for (int k = 0; k < 20; k++) begin
			host.clk_cycle();
			chk("fifo data", drive.data, mem[burst_addr(st, k)]);
		end
		host.idle();
		chk("fifo empty oe", {31'h0, drive.dataOe}, 32'h0);
		$display("Test fifo done");
		final_report();
	end

	// Cut a hang short; the ceiling is several times the expected run.
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 30000) begin
			error_cnt++;
			final_report();
		end
	end
endmodule
`default_nettype wire
